// File: hw/oss_pkg.sv
/*
 * Shared constants and carrier types for the optical servo sequencer.
 * Assumes one 100 MHz clock and squared encoder levels from outside.
 */
package oss_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int WHEEL_DETENTS = 192;
    localparam int CARR_DETENTS = 400;
    localparam int POS_W = 9;
    localparam int DELTA_W = 9;
    localparam int SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // Squared channel bundle: X from A, Y from B, Z from inverted A
    // ------------------------------------------------------------
    typedef struct packed {
        logic sq_x;
        logic sq_y;
        logic sq_z;
    } oss_squared_t;

    // Phase window one-hot selects, window 1 is 315..45 degrees
    typedef struct packed {
        logic win4;
        logic win3;
        logic win2;
        logic win1;
    } oss_window_t;

    // Variant selected into the differentiator
    typedef enum logic [1:0] {
        OSS_SEL_A,
        OSS_SEL_B,
        OSS_SEL_A_N,
        OSS_SEL_B_N
    } oss_diff_sel_t;

endpackage

// File: hw/oss_channel.sv
/*
 * One servo channel: synchroniser, gating logic, phase windows,
 * counting clock, direction and the move sequencer.
 * Assumes quadrature A/B (B lags A by a quarter cycle going forward).
 */
`timescale 1ns/1ps

module oss_channel #(
    parameter int DELTA_W = oss_pkg::DELTA_W
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Squared encoder levels
    input wire oss_pkg::oss_squared_t sq_i,
    // Move command
    input wire logic move_start_i,
    input wire logic [DELTA_W-1:0] move_delta_i,
    // Servo side
    output logic position_mode_o,
    output logic rate_mode_o,
    output logic [DELTA_W-1:0] remaining_o,
    output oss_pkg::oss_window_t window_o,
    output oss_pkg::oss_diff_sel_t diff_sel_o,
    output logic count_pulse_o,
    output logic dir_up_o
);

    // ------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------
    oss_pkg::oss_squared_t meta_reg;
    oss_pkg::oss_squared_t sync_reg;
    oss_pkg::oss_squared_t prev_reg;

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end else begin
            meta_reg <= sq_i;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // ------------------------------------------------------------
    // Gating logic
    // ------------------------------------------------------------
    // Quadrant from A (x with z low) and B (y); z is the independent A-bar squarer
    logic a_hi;
    logic b_hi;
    logic a_fall;
    logic a_rise;
    oss_pkg::oss_window_t win;

    assign a_hi = sync_reg.sq_x & ~sync_reg.sq_z;
    assign b_hi = sync_reg.sq_y;
    assign a_fall = prev_reg.sq_x & ~sync_reg.sq_x;
    assign a_rise = ~prev_reg.sq_x & sync_reg.sq_x;

    always_comb begin
        // Exactly one window from the two-bit quadrant
        win = '0;
        unique case ({a_hi, b_hi})
            2'b10: win.win1 = 1'b1;
            2'b11: win.win2 = 1'b1;
            2'b01: win.win3 = 1'b1;
            2'b00: win.win4 = 1'b1;
        endcase
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            window_o <= '0;
            diff_sel_o <= oss_pkg::OSS_SEL_A;
        end else begin
            window_o <= win;
            if (win.win1) diff_sel_o <= oss_pkg::OSS_SEL_A;
            else if (win.win2) diff_sel_o <= oss_pkg::OSS_SEL_B;
            else if (win.win3) diff_sel_o <= oss_pkg::OSS_SEL_A_N;
            else diff_sel_o <= oss_pkg::OSS_SEL_B_N;
        end
    end

    // ------------------------------------------------------------
    // Counting clock at the A zero crossing (detent)
    // ------------------------------------------------------------
    // Pulse on negative-going A when forward, positive-going when
    // reverse, so the count lands just before the target detent.
    logic pulse;
    logic dir_fwd;
    assign dir_fwd = a_fall ? b_hi : ~b_hi;
    assign pulse = (a_fall & b_hi) | (a_rise & b_hi);

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_pulse_o <= 1'b0;
            dir_up_o <= 1'b1;
        end else begin
            count_pulse_o <= pulse;
            if (pulse) dir_up_o <= dir_fwd;
        end
    end

    // ------------------------------------------------------------
    // Move sequencer
    // ------------------------------------------------------------
    typedef enum logic {OSS_HOLD, OSS_MOVE} oss_seq_t;
    oss_seq_t seq_reg;
    logic [DELTA_W-1:0] delta_reg;

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            seq_reg <= OSS_HOLD;
            delta_reg <= '0;
        end else begin
            unique case (seq_reg)
                OSS_HOLD: begin
                    if (move_start_i && move_delta_i != '0) begin
                        delta_reg <= move_delta_i;
                        seq_reg <= OSS_MOVE;
                    end
                end
                OSS_MOVE: begin
                    if (count_pulse_o) begin
                        delta_reg <= delta_reg - 1'b1;
                        if (delta_reg == DELTA_W'(1))
                            seq_reg <= OSS_HOLD;
                    end
                end
            endcase
        end
    end

    assign position_mode_o = (seq_reg == OSS_HOLD);
    assign rate_mode_o = (seq_reg == OSS_MOVE);
    assign remaining_o = delta_reg;

endmodule

// File: hw/oss_sequencer.sv
/*
 * Top of the optical servo sequencer: printwheel and carriage
 * channels plus the printwheel absolute position counter.
 * Assumes squared encoder inputs synchronous-ish to mclk_i; they are
 * re-synchronised here anyway.
 */
// What this block does
// - Two channels are squared by three threshold circuits into X, Y, Z.
// - Gating of X, Y, Z gives the counting pulse and four window selects.
// - Each detent is an A zero crossing, held at a negative-going null.
// - The printwheel count runs modulo 192 detents.
// - The carriage has 400 detents per turn, one per counted pulse.
// - A move first drops position mode, then counts pulses on the way.
// - When the count reaches the target, position mode returns.
// - With position mode off the servo runs in rate mode on remaining error.
// - Windows select A, B, inverted A, inverted B in quarter steps.
// - Exactly one window select is active from the first edge after reset; reset clears all four.
// - Both servo channels use the same windowed velocity sampling.
// - The printwheel index is squared separately as absolute reference.
// - The carriage has no index and moves only by relative counts.
// - Wheel position clears on pulse with index, else steps by direction.
// - The delta counter counts down per pulse; zero restores position.
`timescale 1ns/1ps

module oss_sequencer #(
    parameter int WHEEL_DETENTS = oss_pkg::WHEEL_DETENTS,
    parameter int CARR_DETENTS = oss_pkg::CARR_DETENTS
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Printwheel encoder and index
    input wire oss_pkg::oss_squared_t wheel_sq_i,
    input wire logic wheel_index_i,
    // Carriage encoder
    input wire oss_pkg::oss_squared_t carr_sq_i,
    // Move commands
    input wire logic wheel_start_i,
    input wire logic [oss_pkg::DELTA_W-1:0] wheel_delta_i,
    input wire logic carr_start_i,
    input wire logic [oss_pkg::DELTA_W-1:0] carr_delta_i,
    // Printwheel servo side
    output logic wheel_position_mode_o,
    output logic wheel_rate_mode_o,
    output logic [oss_pkg::DELTA_W-1:0] wheel_remaining_o,
    output oss_pkg::oss_window_t wheel_window_o,
    output oss_pkg::oss_diff_sel_t wheel_diff_sel_o,
    output logic wheel_pulse_o,
    output logic [oss_pkg::POS_W-1:0] wheel_position_o,
    output logic wheel_index_o,
    // Carriage servo side
    output logic carr_position_mode_o,
    output logic carr_rate_mode_o,
    output logic [oss_pkg::DELTA_W-1:0] carr_remaining_o,
    output oss_pkg::oss_window_t carr_window_o,
    output oss_pkg::oss_diff_sel_t carr_diff_sel_o,
    output logic carr_pulse_o,
    output logic carr_dir_up_o,
    output logic [oss_pkg::POS_W-1:0] carr_phase_o
);

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    logic wheel_dir_up;

    oss_channel u_wheel (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .sq_i(wheel_sq_i),
        .move_start_i(wheel_start_i),
        .move_delta_i(wheel_delta_i),
        .position_mode_o(wheel_position_mode_o),
        .rate_mode_o(wheel_rate_mode_o),
        .remaining_o(wheel_remaining_o),
        .window_o(wheel_window_o),
        .diff_sel_o(wheel_diff_sel_o),
        .count_pulse_o(wheel_pulse_o),
        .dir_up_o(wheel_dir_up)
    );

    oss_channel u_carr (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .sq_i(carr_sq_i),
        .move_start_i(carr_start_i),
        .move_delta_i(carr_delta_i),
        .position_mode_o(carr_position_mode_o),
        .rate_mode_o(carr_rate_mode_o),
        .remaining_o(carr_remaining_o),
        .window_o(carr_window_o),
        .diff_sel_o(carr_diff_sel_o),
        .count_pulse_o(carr_pulse_o),
        .dir_up_o(carr_dir_up_o)
    );

    // ------------------------------------------------------------
    // Index synchroniser
    // ------------------------------------------------------------
    // Index is delayed one extra stage to line up with the pulse
    logic idx_meta_reg;
    logic idx_sync_reg;
    logic idx_align_reg;

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            idx_meta_reg <= 1'b0;
            idx_sync_reg <= 1'b0;
            idx_align_reg <= 1'b0;
        end else begin
            idx_meta_reg <= wheel_index_i;
            idx_sync_reg <= idx_meta_reg;
            idx_align_reg <= idx_sync_reg;
        end
    end

    assign wheel_index_o = idx_align_reg;

    // ------------------------------------------------------------
    // Printwheel absolute position
    // ------------------------------------------------------------
    localparam logic [oss_pkg::POS_W-1:0] WHEEL_TOP =
        oss_pkg::POS_W'(WHEEL_DETENTS - 1);
    localparam logic [oss_pkg::POS_W-1:0] CARR_TOP =
        oss_pkg::POS_W'(CARR_DETENTS - 1);

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wheel_position_o <= '0;
        end else if (wheel_pulse_o) begin
            if (idx_align_reg)
                wheel_position_o <= '0;
            else if (wheel_dir_up)
                wheel_position_o <= (wheel_position_o == WHEEL_TOP) ?
                    '0 : wheel_position_o + 1'b1;
            else
                wheel_position_o <= (wheel_position_o == '0) ?
                    WHEEL_TOP : wheel_position_o - 1'b1;
        end
    end

    // Carriage detent phase within one motor turn, relative only
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            carr_phase_o <= '0;
        end else if (carr_pulse_o) begin
            if (carr_dir_up_o)
                carr_phase_o <= (carr_phase_o == CARR_TOP) ?
                    '0 : carr_phase_o + 1'b1;
            else
                carr_phase_o <= (carr_phase_o == '0) ?
                    CARR_TOP : carr_phase_o - 1'b1;
        end
    end

endmodule

// File: verification/oss_assertions.sv
/* Port checker for the printwheel side of oss_sequencer.
   Bound to every oss_sequencer; one clock, async active-low reset. */
`timescale 1ns/1ps
module oss_assertions #(
    parameter int WHEEL_DETENTS = oss_pkg::WHEEL_DETENTS,
    parameter int CARR_DETENTS = oss_pkg::CARR_DETENTS
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Watched ports
    input wire logic wheel_start_i,
    input wire logic [oss_pkg::DELTA_W-1:0] wheel_delta_i,
    input wire logic wheel_position_mode_o,
    input wire logic wheel_rate_mode_o,
    input wire logic [oss_pkg::DELTA_W-1:0] wheel_remaining_o,
    input wire oss_pkg::oss_window_t wheel_window_o,
    input wire oss_pkg::oss_diff_sel_t wheel_diff_sel_o,
    input wire logic wheel_pulse_o
);
    // ------------------------------------------------------------
    // Sequencer and window checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!reset_n_i);

    AST_RATE_INV: assert property (
        wheel_rate_mode_o == !wheel_position_mode_o)
        else $error("rate mode not inverse of position mode");
    AST_START_TAKEN: assert property (
        wheel_position_mode_o && wheel_start_i && wheel_delta_i != 9'h000
        |=> !wheel_position_mode_o
            && wheel_remaining_o == $past(wheel_delta_i))
        else $error("start not taken");
    AST_ZERO_REFUSED: assert property (
        wheel_position_mode_o && wheel_start_i && wheel_delta_i == 9'h000
        |=> wheel_position_mode_o)
        else $error("zero move left position mode");
    AST_COUNT_DOWN: assert property (
        !wheel_position_mode_o && wheel_pulse_o
            && wheel_remaining_o > 9'h001
        |=> !wheel_position_mode_o
            && wheel_remaining_o == $past(wheel_remaining_o) - 9'h001)
        else $error("remaining count did not step down");
    AST_TARGET_DONE: assert property (
        !wheel_position_mode_o && wheel_pulse_o
            && wheel_remaining_o == 9'h001
        |=> wheel_position_mode_o && wheel_remaining_o == 9'h000)
        else $error("position mode not restored at target");
    // Window is 0000 until the first edge after release
    AST_WIN_ONEHOT: assert property (
        $past(reset_n_i) |-> $onehot(wheel_window_o))
        else $error("window selects not one-hot");
    AST_SEL_A: assert property (
        wheel_window_o.win1 |-> wheel_diff_sel_o == oss_pkg::OSS_SEL_A)
        else $error("first window does not select A");
    AST_PULSE_SINGLE: assert property (
        wheel_pulse_o |=> !wheel_pulse_o)
        else $error("counting pulse longer than one cycle");
endmodule

bind oss_sequencer oss_assertions #(
    .WHEEL_DETENTS(WHEEL_DETENTS),
    .CARR_DETENTS(CARR_DETENTS)
) u_oss_chk (
    .mclk_i, .reset_n_i, .wheel_start_i, .wheel_delta_i,
    .wheel_position_mode_o, .wheel_rate_mode_o, .wheel_remaining_o,
    .wheel_window_o, .wheel_diff_sel_o, .wheel_pulse_o
);

// File: verification/oss_enc_model.sv
/* Photohead stand-in: quadrature A/B squared to X, Y, Z and an index.
   Moved a quarter cycle per strobe from the bench, on mclk_i. */
`timescale 1ns/1ps
module oss_enc_model (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Step control
    input wire logic quarter_i,
    input wire logic fwd_i,
    input wire logic index_en_i,
    // Squared outputs
    output oss_pkg::oss_squared_t sq_o,
    output logic index_o
);
    logic [1:0] phase_reg;
    logic a_hi;
    logic b_hi;

    // ------------------------------------------------------------
    // Shaft phase in quarter cycles
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            phase_reg <= 2'h3;
        end else if (quarter_i) begin
            phase_reg <= fwd_i ? phase_reg + 2'h1 : phase_reg - 2'h1;
        end
    end

    // B lags A a quarter going forward
    assign a_hi = (phase_reg == 2'h0) || (phase_reg == 2'h1);
    assign b_hi = (phase_reg == 2'h1) || (phase_reg == 2'h2);
    assign sq_o = {a_hi, b_hi, !a_hi};
    // One slot per quadrature cycle (phase 2), only where the bench arms it
    assign index_o = index_en_i && (phase_reg == 2'h2);
endmodule

// File: verification/tb.sv
/* Self-checking bench for oss_sequencer driven by two encoder models.
   Assumes three edges from encoder pin to counting pulse. */
`timescale 1ns/1ps
module tb;
    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [1:0] quarter = 2'h0;
    logic [1:0] fwd = 2'h3;
    logic index_en = 1'b0;
    logic wheel_start = 1'b0;
    logic carr_start = 1'b0;
    logic [8:0] wheel_delta = 9'h000;
    logic [8:0] carr_delta = 9'h000;
    logic [1:0] ph [2] = '{2'h3, 2'h3};
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    oss_pkg::oss_squared_t wheel_sq;
    oss_pkg::oss_squared_t carr_sq;
    wire wheel_index;
    wire wheel_idx;
    wire carr_dir;
    wire [1:0] pmode;
    wire [1:0] rmode;
    wire [1:0] pulse;
    wire [8:0] rem [2];
    wire [3:0] win [2];
    wire [1:0] sel [2];
    wire [8:0] wheel_pos;
    wire [8:0] carr_phase;

    // ------------------------------------------------------------
    // Design and encoders
    // ------------------------------------------------------------
    oss_sequencer dut (
        .mclk_i, .reset_n_i, .wheel_sq_i(wheel_sq),
        .wheel_index_i(wheel_index), .carr_sq_i(carr_sq),
        .wheel_start_i(wheel_start), .wheel_delta_i(wheel_delta),
        .carr_start_i(carr_start), .carr_delta_i(carr_delta),
        .wheel_position_mode_o(pmode[0]), .wheel_rate_mode_o(rmode[0]),
        .wheel_remaining_o(rem[0]), .wheel_window_o(win[0]),
        .wheel_diff_sel_o(sel[0]), .wheel_pulse_o(pulse[0]),
        .wheel_position_o(wheel_pos), .wheel_index_o(wheel_idx),
        .carr_position_mode_o(pmode[1]), .carr_rate_mode_o(rmode[1]),
        .carr_remaining_o(rem[1]), .carr_window_o(win[1]),
        .carr_diff_sel_o(sel[1]), .carr_pulse_o(pulse[1]),
        .carr_dir_up_o(carr_dir), .carr_phase_o(carr_phase)
    );
    oss_enc_model u_wheel_enc (.mclk_i, .reset_n_i,
        .quarter_i(quarter[0]), .fwd_i(fwd[0]), .index_en_i(index_en),
        .sq_o(wheel_sq), .index_o(wheel_index));
    // Carriage head has no index cell
    oss_enc_model u_carr_enc (.mclk_i, .reset_n_i,
        .quarter_i(quarter[1]), .fwd_i(fwd[1]), .index_en_i(1'b0),
        .sq_o(carr_sq), .index_o());

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    always #5 mclk_i = ~mclk_i;

    task automatic tick();
        @(posedge mclk_i);
        #1;
    endtask

    task automatic chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            failures++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Each quarter step also checks the windows once settled
    task automatic quarter_step(input int ch, input logic dir);
        fwd[ch] = dir;
        quarter[ch] = 1'b1;
        tick();
        quarter[ch] = 1'b0;
        ph[ch] = dir ? ph[ch] + 2'h1 : ph[ch] - 2'h1;
        repeat (5) tick();
        chk(win[ch] === 4'h1 << ph[ch], "window select");
        chk(sel[ch] === ph[ch], "differentiator select");
    endtask

    task automatic detent(input int ch, input logic dir, input int n);
        repeat (4 * n) quarter_step(ch, dir);
    endtask

    task automatic start_move(input int ch, input logic [8:0] d);
        // One idle edge so back-to-back calls never glitch the strobe
        tick();
        wheel_delta = d;
        carr_delta = d;
        wheel_start = (ch == 0);
        carr_start = (ch == 1);
        tick();
        wheel_start = 1'b0;
        carr_start = 1'b0;
        chk(pmode[ch] === (d == 9'h000), "mode after start");
        chk(rem[ch] === d, "remaining after start");
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_wheel_move();
        start_move(0, 9'h000);
        start_move(0, 9'h003);
        detent(0, 1'b1, 2);
        wheel_delta = 9'h005;
        wheel_start = 1'b1;
        tick();
        wheel_start = 1'b0;
        chk(rem[0] === 9'h001 && rmode[0] === 1'b1, "rate mode");
        detent(0, 1'b1, 1);
        chk(pmode[0] === 1'b1 && rem[0] === 9'h000, "end");
        chk(wheel_pos === 9'h003, "wheel position");
    endtask

    task automatic t_wheel_index();
        index_en = 1'b1;
        // Stop on the index quarter so the aligned index can be seen
        repeat (3) quarter_step(0, 1'b1);
        chk(wheel_idx === 1'b1, "index seen");
        chk(wheel_pos === 9'h000, "index clear");
        quarter_step(0, 1'b1);
        chk(wheel_idx === 1'b0, "index gone");
        index_en = 1'b0;
        detent(0, 1'b0, 1);
        chk(wheel_pos === 9'h0bf, "wheel wrap");
    endtask

    task automatic t_carriage();
        detent(1, 1'b1, 1);
        chk(carr_phase === 9'h001 && carr_dir === 1'b1, "fwd");
        start_move(1, 9'h002);
        detent(1, 1'b0, 2);
        chk(pmode[1] === 1'b1 && rem[1] === 9'h000, "end");
        chk(carr_phase === 9'h18f && carr_dir === 1'b0, "wrap");
    endtask

    // Hang guard; the whole run needs a few hundred cycles
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            end_sim();
        end
    end

    initial begin
        repeat (8) @(posedge mclk_i);
        #1;
        reset_n_i = 1'b1;
        tick();
        chk(pmode === 2'h3 && rmode === 2'h0, "reset modes");
        t_wheel_move();
        t_wheel_index();
        t_carriage();
        end_sim();
    end
endmodule
